// ===== epil_params.svh
// register offsets, field positions, vector addresses for the external pin interrupt latch
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef EPIL_PARAMS_SVH
`define EPIL_PARAMS_SVH
`define EPIL_ADDR_W 4
`define EPIL_STATUS_CONTROL_OFS 4'h0
`define EPIL_BREAK_CTRL_OFS 4'h4
`define EPIL_VECTOR_OFS 4'h8
`define EPIL_MODE_BIT 0
`define EPIL_MASK_BIT 1
`define EPIL_CLEAR_BIT 2
`define EPIL_PEND_BIT 3
`define EPIL_PIN_LEVEL_BIT 4
`define EPIL_BREAK_CLEAR_ENABLE_BIT_BIT 0
`define EPIL_BREAK_STATE_BIT 1
`define EPIL_VECTOR_HI 16'hfffa
`define EPIL_VECTOR_LO 16'hfffb
`endif

// ===== epil_pkg.sv
// types for the external pin interrupt latch
// assumes nothing beyond the params header
package epil_pkg;
  typedef enum logic [1:0] {EPIL_IDLE, EPIL_ACK} epil_bus_t;
endpackage : epil_pkg

// ===== epil_pin_sync.sv
// two-stage synchroniser and falling-edge detector for the pin
// assumes the pin is asynchronous to mclk and idles high
`timescale 1ns/100ps
module epil_pin_sync (
  // clock
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // pin
  input wire logic extIntPinN,
  // result
  output logic pinLow,
  output logic fallEdge
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;
  always_comb
  begin
    next_meta = ce ? extIntPinN : meta;
    next_sync = ce ? meta : sync;
    next_prev = ce ? sync : prev;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end
  // high sample then low sample; meta only feeds sync
  assign fallEdge = prev & ~sync;
  assign pinLow = ~sync;
endmodule : epil_pin_sync

// ===== epil_latch.sv
// request latch with edge or edge-and-level sensitivity
// assumes ack is a one-cycle pulse on mclk
`timescale 1ns/100ps
module epil_latch (
  // clock
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // events
  input wire logic fallEdge,
  input wire logic pinLow,
  input wire logic levelMode,
  input wire logic ack,
  // state
  output logic pending
);
  logic latch;
  logic next_latch;
  always_comb
  begin
    next_latch = latch;
    if (ce)
    begin
      if (ack)
        next_latch = 1'b0;
      // set wins over clear, a fresh edge is never lost
      if (fallEdge)
        next_latch = 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      latch <= 1'b0;
    else
      latch <= next_latch;
  end
  // level mode keeps the request alive while the pin is low
  assign pending = latch | (levelMode & pinLow);
endmodule : epil_latch

// ===== epil_top.sv
// Summary of operation
// - a falling pin edge sets the request latch in either sensitivity.
// - the cpu vector-fetch acknowledge clears the latch.
// - writing 1 to the clear bit acts like a vector fetch acknowledge.
// - reset clears the latch and the sensitivity bit, even with pin low; a pin held low through reset still sets the latch three clocks later.
// - sensitivity 0 means falling edge only; acknowledge clears at once.
// - sensitivity 1 needs acknowledge and pin high, any order, to clear.
// - in level mode request stays pending while the pin is low.
// - mask set withholds the request from cpu priority logic.
// - an edge after a software acknowledge latches a new request.
// - the taken interrupt fetches its vector from the fixed address pair.
// - pending flag ignores the mask so software can poll.
// - clear bit is write-only and reads 0; reset clears it.
// - pending flag is read-only, 1 while pending.
// - in break state clear-bit writes work only when break clear-enable is 1.
//
// top of the external pin interrupt latch with a wishbone register slave
// assumes a classic wishbone master on mclk and an asynchronous pin
`timescale 1ns/100ps
`include "epil_params.svh"
module epil_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // pin and cpu side
  input wire logic extIntPinN,
  input wire logic vectorFetchAck,
  input wire logic breakState,
  output logic irqRequest,
  output logic [15:0] vectorAddr
);
  logic pinLow;
  logic fallEdge;
  logic pending;
  logic levelMode;
  logic maskBit;
  logic breakClearEnable;
  logic next_levelMode;
  logic next_maskBit;
  logic next_breakClearEnable;
  logic next_irqRequest;
  logic [15:0] next_vectorAddr;
  epil_pkg::epil_bus_t busState;
  epil_pkg::epil_bus_t next_busState;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic next_wb_err_o;
  logic accessNow;
  logic writeNow;
  logic hitCtrl;
  logic hitBreak;
  logic hitVector;
  logic swAck;
  logic ackAll;

  epil_pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .extIntPinN(extIntPinN),
    .pinLow(pinLow),
    .fallEdge(fallEdge)
  );

  epil_latch u_latch (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .fallEdge(fallEdge),
    .pinLow(pinLow),
    .levelMode(levelMode),
    .ack(ackAll),
    .pending(pending)
  );

  // one access per request: answer once, then idle a cycle
  assign accessNow = wb_cyc_i & wb_stb_i & (busState == epil_pkg::EPIL_IDLE) & ce;
  assign writeNow = accessNow & wb_we_i & wb_sel_i[0];
  assign hitCtrl = (wb_adr_i[`EPIL_ADDR_W-1:0] == `EPIL_STATUS_CONTROL_OFS)
                   & (wb_adr_i[31:`EPIL_ADDR_W] == 28'h0000000);
  assign hitBreak = (wb_adr_i[`EPIL_ADDR_W-1:0] == `EPIL_BREAK_CTRL_OFS)
                    & (wb_adr_i[31:`EPIL_ADDR_W] == 28'h0000000);
  assign hitVector = (wb_adr_i[`EPIL_ADDR_W-1:0] == `EPIL_VECTOR_OFS)
                     & (wb_adr_i[31:`EPIL_ADDR_W] == 28'h0000000);
  // clear bit is a strobe, never stored; break state may lock it out
  assign swAck = writeNow & hitCtrl & wb_dat_i[`EPIL_CLEAR_BIT]
                 & (~breakState | breakClearEnable);
  assign ackAll = vectorFetchAck | swAck;

  always_comb
  begin
    next_levelMode = levelMode;
    next_maskBit = maskBit;
    next_breakClearEnable = breakClearEnable;
    next_busState = busState;
    next_wb_dat_o = wb_dat_o;
    // a low ce freezes the answer as well, so a pending ack is not lost
    next_wb_ack_o = wb_ack_o;
    next_wb_err_o = wb_err_o;
    next_irqRequest = irqRequest;
    next_vectorAddr = vectorAddr;
    if (ce)
    begin
      next_wb_ack_o = 1'b0;
      next_wb_err_o = 1'b0;
      next_irqRequest = pending & ~maskBit;
      next_vectorAddr = `EPIL_VECTOR_HI;
      case (busState)
        epil_pkg::EPIL_IDLE:
        begin
          if (accessNow)
          begin
            next_busState = epil_pkg::EPIL_ACK;
            next_wb_dat_o = 32'h00000000;
            if (hitCtrl | hitBreak | hitVector)
              next_wb_ack_o = 1'b1;
            else
              next_wb_err_o = 1'b1;
            if (hitCtrl)
            begin
              next_wb_dat_o[`EPIL_MODE_BIT] = levelMode;
              next_wb_dat_o[`EPIL_MASK_BIT] = maskBit;
              next_wb_dat_o[`EPIL_CLEAR_BIT] = 1'b0;
              next_wb_dat_o[`EPIL_PEND_BIT] = pending;
              next_wb_dat_o[`EPIL_PIN_LEVEL_BIT] = ~pinLow;
            end
            if (hitBreak)
            begin
              next_wb_dat_o[`EPIL_BREAK_CLEAR_ENABLE_BIT_BIT] = breakClearEnable;
              next_wb_dat_o[`EPIL_BREAK_STATE_BIT] = breakState;
            end
            if (hitVector)
              next_wb_dat_o[15:0] = `EPIL_VECTOR_HI;
            if (writeNow & hitCtrl)
            begin
              next_levelMode = wb_dat_i[`EPIL_MODE_BIT];
              next_maskBit = wb_dat_i[`EPIL_MASK_BIT];
            end
            if (writeNow & hitBreak)
              next_breakClearEnable = wb_dat_i[`EPIL_BREAK_CLEAR_ENABLE_BIT_BIT];
          end
        end
        epil_pkg::EPIL_ACK:
          next_busState = epil_pkg::EPIL_IDLE;
        default:
          next_busState = epil_pkg::EPIL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      levelMode <= 1'b0;
      maskBit <= 1'b0;
      breakClearEnable <= 1'b0;
      busState <= epil_pkg::EPIL_IDLE;
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      irqRequest <= 1'b0;
      vectorAddr <= 16'h0000;
    end
    else
    begin
      levelMode <= next_levelMode;
      maskBit <= next_maskBit;
      breakClearEnable <= next_breakClearEnable;
      busState <= next_busState;
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
      wb_err_o <= next_wb_err_o;
      irqRequest <= next_irqRequest;
      vectorAddr <= next_vectorAddr;
    end
  end
endmodule : epil_top

// ===== epil_top_sva.sv
// bus answer, vector and request checks on the latch top ports
// assumes ce high and a single-word wishbone master
`timescale 1ns/100ps
module epil_top_sva (
  // clock
  input logic mclk,
  input logic rst,
  input logic ce,
  // bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [31:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic wb_err_o,
  // pin and cpu
  input logic extIntPinN,
  input logic vectorFetchAck,
  input logic irqRequest,
  input logic [15:0] vectorAddr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire req = ce && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire rdAck = wb_ack_o && !wb_we_i;
  // six high samples flush any edge still in the synchroniser
  sequence s_pin_idle;
    extIntPinN [*6];
  endsequence
  a_ack_resp: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered once");
  a_err_unmapped: assert property (req && wb_adr_i == 32'hc |=> wb_err_o)
    else $error("unmapped access not refused");
  a_clr_zero: assert property (rdAck && wb_adr_i == 32'h0 |->
    wb_dat_o[31:5] == 27'h0 && !wb_dat_o[2])
    else $error("clear bit read back set");
  a_vec_read: assert property (rdAck && wb_adr_i == 32'h8 |-> wb_dat_o == 32'hfffa)
    else $error("vector register wrong");
  a_vec_fixed: assert property (!$past(rst) |-> vectorAddr == 16'hfffa)
    else $error("vector address wrong");
  a_rst_quiet: assert property ($past(rst) |-> !irqRequest)
    else $error("request just after reset");
  a_fetch_clr: assert property (s_pin_idle ##0 vectorFetchAck |-> ##[1:2] !irqRequest)
    else $error("fetch did not clear request");
  a_irq_cause: assert property ($rose(irqRequest) |-> !$past(extIntPinN, 3) ||
    !$past(extIntPinN, 4) || $past(wb_cyc_i) || $past(wb_cyc_i, 2))
    else $error("request without pin or write");
endmodule : epil_top_sva
bind epil_top epil_top_sva u_epil_top_sva (.*);

// ===== epil_cpu_model.sv
// cpu side: takes the request and answers with a vector fetch pulse
// assumes mclk; slow adds wait states before the fetch
`timescale 1ns/100ps
module epil_cpu_model (
  // clock
  input logic mclk,
  input logic rst,
  // control and request
  input logic globalMask,
  input logic slow,
  input logic irqRequest,
  output logic vectorFetchAck
);
  logic [2:0] cnt;
  wire take = irqRequest && !globalMask;
  // wait of at least 3 keeps the fetch from repeating while the request drains
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      cnt <= 3'h0;
      vectorFetchAck <= 1'h0;
    end
    else
    begin
      vectorFetchAck <= take && cnt == (slow ? 3'h7 : 3'h3);
      cnt <= (take && !vectorFetchAck) ? cnt + 3'h1 : 3'h0;
    end
endmodule : epil_cpu_model

// ===== test_epil_top.sv
// register and pin tests of the latch top with a cpu model
// assumes all byte lanes enabled; ce drops once to check the freeze
`timescale 1ns/100ps
module test_epil_top;
  logic mclk, rst, cyc, stb, we, pinN, brk, gMask, slow, fetch, irq, ack, err, gotErr;
  logic [31:0] adr, wdat, rdat, q;
  logic [15:0] vec;
  logic ce;
  int err_total = 0;
  int n_tests = 0;
  epil_top u_epil_top (.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .extIntPinN(pinN), .vectorFetchAck(fetch),
    .breakState(brk), .irqRequest(irq), .vectorAddr(vec));
  epil_cpu_model u_epil_cpu_model (.mclk(mclk), .rst(rst), .globalMask(gMask),
    .slow(slow), .irqRequest(irq), .vectorFetchAck(fetch));
  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  task results;
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task bus(input logic w, input logic [31:0] a, d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (!(ack || err));
    q = rdat;
    gotErr = err;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge mclk);
  endtask : bus
  task rd(input logic [31:0] a, e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task pulse(input int n);
    pinN <= 1'h0;
    tick(n);
    pinN <= 1'h1;
  endtask : pulse
  initial
  begin
    tick(2000);
    err_total++;
    results();
  end
  initial
  begin
    {rst, cyc, stb, we, brk, gMask, slow, pinN} = 8'h85;
    adr = 32'h0;
    wdat = 32'h0;
    ce = 1'h1;
    tick(6);
    rst <= 1'h0;
    tick(1);
    rd(32'h0, 32'h10);
    rd(32'h8, 32'hfffa);
    chk({16'h0, vec}, 32'hfffa);
    bus(1'h0, 32'hc, 32'h0);
    chk({31'h0, gotErr}, 32'h1);
    pinN <= 1'h0;
    tick(8);
    rd(32'h0, 32'h08);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, 32'h0, 32'h2);
    rd(32'h0, 32'h0a);
    chk({31'h0, irq}, 32'h0);
    bus(1'h1, 32'h0, 32'h6);
    rd(32'h0, 32'h02);
    pinN <= 1'h1;
    tick(4);
    pulse(8);
    // let the high pin pass the synchroniser before the level bit is read
    tick(4);
    rd(32'h0, 32'h1a);
    bus(1'h1, 32'h0, 32'h5);
    // level mode: pin back high without any acknowledge
    pulse(4);
    tick(8);
    rd(32'h0, 32'h19);
    gMask <= 1'h0;
    tick(16);
    rd(32'h0, 32'h11);
    slow <= 1'h1;
    pinN <= 1'h0;
    tick(30);
    rd(32'h0, 32'h09);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, 32'h0, 32'h3);
    chk({31'h0, irq}, 32'h0);
    gMask <= 1'h1;
    pinN <= 1'h1;
    tick(8);
    pulse(4);
    brk <= 1'h1;
    tick(8);
    bus(1'h1, 32'h0, 32'h5);
    rd(32'h0, 32'h19);
    bus(1'h1, 32'h4, 32'h1);
    rd(32'h4, 32'h3);
    bus(1'h1, 32'h0, 32'h5);
    rd(32'h0, 32'h11);
    // a pin pulse while ce is low must leave no trace
    ce <= 1'h0;
    pulse(4);
    tick(4);
    ce <= 1'h1;
    tick(8);
    rd(32'h0, 32'h11);
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule : test_epil_top
